// ### rtl/mas_pkg.sv
/*
 Package for the manual/automatic simultaneous axis arbiter: axis count,
 error codes and reset values. Assumes one 100 MHz clock.
*/
`default_nettype none
package mas_pkg;
   localparam int unsigned NUM_AXES        = 8;
   localparam logic [15:0] ERR_NONE        = 16'h0000;
   localparam logic [15:0] ERR_AXIS_CONFL  = 16'h0005;
   localparam logic [15:0] ERR_COORD_WORD  = 16'h0006;
   localparam logic [7:0]  AXES_RST        = 8'h00;
   localparam logic [1:0]  MOVE_NONE       = 2'h0;
   localparam logic [1:0]  MOVE_RAPID      = 2'h1;
   localparam logic [1:0]  MOVE_CUT        = 2'h2;
   typedef enum logic [1:0] {AX_AUTO, AX_STOPPING, AX_MANUAL} axis_state_t;
endpackage
`default_nettype wire

// ### rtl/manual_auto_simultaneous_axis_ctrl.sv
/*
 Per-axis arbitration for combined manual/automatic operation.
 Assumes PLC inputs synchronous to clk_in; scan_strobe_in marks one PLC scan.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// [RULE_01] Combined mode only while an auto and a manual mode are both selected.
// [RULE_02] One manual select bit per axis, one to eight, driven by the PLC.
// [RULE_03] Auto command on manual axis raises error 0005 and interlocks auto.
// [RULE_04] Auto only: select bits ignored, no interlock applied.
// [RULE_05] Select rising on auto-moving axis: interlock, stop, error 0005, tap too.
// [RULE_06] Once stopped, manual commands accepted on that axis.
// [RULE_07] Manual commands rejected on unselected axes; handle interrupt still allowed.
// [RULE_08] Separate feedrate and accel mode for auto and manual axes.
// [RULE_09] Overrides to both classes; cutting on manual if enabled; cancel auto only.
// [RULE_10] Manual interlocks gate manual axes, auto interlocks gate auto axes.
// [RULE_11] Cutting and rapid status follow auto axes only.
// [RULE_12] Manual motion continues through single block stop and feed hold.
// [RULE_13] Coordinate commands wait for manual stop; axis word on G53 errors.
// [RULE_14] Limit trip on manual axis stops auto axes and enters feed hold.
// [RULE_15] Unselected axes follow automatic handle interrupt rules.
// [RULE_16] Tape, MDI, memory automatic; handle, step, jog, ref return manual.
// [RULE_17] Interlock inputs are active low.
// [RULE_18] Inputs sampled once per scan; transitions between consecutive samples. Code samples only mode and axis select inputs per scan.
module manual_auto_simultaneous_axis_ctrl #(
   parameter int unsigned N = mas_pkg::NUM_AXES
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // PLC scan and mode selects
   input  wire logic         scan_strobe_in,
   input  wire logic         mode_tape_in,
   input  wire logic         mode_mdi_in,
   input  wire logic         mode_memory_in,
   input  wire logic         mode_handle_in,
   input  wire logic         mode_step_in,
   input  wire logic         mode_jog_in,
   input  wire logic         mode_refret_in,
   input  wire logic [N-1:0] manual_during_auto_axis_select_in,
   // Motion commands and axis status
   input  wire logic [N-1:0] auto_cmd_in,
   input  wire logic         tap_modal_in,
   input  wire logic [N-1:0] manual_cmd_in,
   input  wire logic [N-1:0] handle_intr_in,
   input  wire logic [N-1:0] axis_moving_in,
   input  wire logic [N-1:0] limit_trip_in,
   input  wire logic         coord_cmd_in,
   input  wire logic         coord_axis_word_in,
   input  wire logic         error_clear_in,
   // Interlocks, active low
   input  wire logic [N-1:0] manual_ilk_n_in,
   input  wire logic [N-1:0] auto_ilk_n_in,
   // Feed control
   input  wire logic         single_block_stop_in,
   input  wire logic         feed_hold_in,
   input  wire logic [7:0]   rapid_ovr_in,
   input  wire logic [7:0]   cut_ovr_in,
   input  wire logic [7:0]   cut2_ovr_in,
   input  wire logic         manual_cut_ovr_en_in,
   input  wire logic         ovr_cancel_in,
   input  wire logic [15:0]  auto_feed_in,
   input  wire logic [15:0]  manual_feed_in,
   input  wire logic [1:0]   auto_move_mode_in,
   input  wire logic [1:0]   manual_move_mode_in,
   // Status and per-axis enables
   output logic              combined_mode_out,
   output logic [15:0]       op_error_out,
   output logic              auto_interlock_out,
   output logic              feed_hold_out,
   output logic [N-1:0]      auto_axis_enable_out,
   output logic [N-1:0]      manual_axis_enable_out,
   output logic [N-1:0]      decel_stop_out,
   output logic              coord_exec_out,
   output logic              in_cutting_out,
   output logic              in_rapid_out,
   output logic [15:0]       auto_feed_out,
   output logic [15:0]       manual_feed_out,
   output logic [1:0]        auto_accel_mode_out,
   output logic [1:0]        manual_accel_mode_out,
   output logic [7:0]        auto_cut_ovr_out,
   output logic [7:0]        manual_cut_ovr_out,
   output logic [7:0]        auto_rapid_ovr_out,
   output logic [7:0]        manual_rapid_ovr_out
);

   function automatic logic any_bit(input logic [N-1:0] v);
      any_bit = |v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Scan sampling
   logic         auto_sel_ff;
   logic         man_sel_ff;
   logic [N-1:0] sel_ff;
   logic [N-1:0] sel_prev_ff;
   logic         combined;
   logic [N-1:0] eff_sel;
   logic [N-1:0] sel_rise;

   // [RULE_18] Sample once per scan
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auto_sel_ff <= 1'b0;
         man_sel_ff  <= 1'b0;
         sel_ff      <= '0;
         sel_prev_ff <= '0;
      end else if (scan_strobe_in) begin
         // [RULE_16] Mode classes
         auto_sel_ff <= mode_tape_in | mode_mdi_in | mode_memory_in;
         man_sel_ff  <= mode_handle_in | mode_step_in | mode_jog_in | mode_refret_in;
         // [RULE_02] Per-axis select
         sel_ff      <= manual_during_auto_axis_select_in;
         sel_prev_ff <= sel_ff;
      end
   end

   // [RULE_01] Combined mode entry
   assign combined = auto_sel_ff & man_sel_ff;
   // [RULE_04] Selects ignored outside combined
   assign eff_sel  = combined ? sel_ff : '0;
   assign sel_rise = eff_sel & ~sel_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Per-axis state
   mas_pkg::axis_state_t st_ff [N];
   logic [N-1:0] stopping;
   logic [N-1:0] manual_own;

   for (genvar i = 0; i < N; i++) begin : g_axis
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            st_ff[i] <= mas_pkg::AX_AUTO;
         end else begin
            case (st_ff[i])
               mas_pkg::AX_AUTO: begin
                  // [RULE_05] Forced stop on rise, tap modal included
                  if (sel_rise[i] && axis_moving_in[i])
                     st_ff[i] <= mas_pkg::AX_STOPPING;
                  else if (eff_sel[i])
                     st_ff[i] <= mas_pkg::AX_MANUAL;
               end
               mas_pkg::AX_STOPPING: begin
                  // [RULE_06] Manual after stop
                  if (!axis_moving_in[i])
                     st_ff[i] <= eff_sel[i] ? mas_pkg::AX_MANUAL : mas_pkg::AX_AUTO;
               end
               default: begin
                  if (!eff_sel[i])
                     st_ff[i] <= mas_pkg::AX_AUTO;
               end
            endcase
         end
      end
      assign stopping[i]   = (st_ff[i] == mas_pkg::AX_STOPPING);
      assign manual_own[i] = (st_ff[i] == mas_pkg::AX_MANUAL);

      // Forced stop steps, per axis
      sequence s_stop_start;
         sel_rise[i] && axis_moving_in[i] && st_ff[i] == mas_pkg::AX_AUTO;
      endsequence
      sequence s_stop_shown;
         stopping[i] ##1 decel_stop_out[i];
      endsequence
      AST_STOP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_05]
         s_stop_start |=> s_stop_shown)
         else $error("forced stop missing");
      AST_STOP_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_05]
         s_stop_start |=> !auto_axis_enable_out[i] && op_error_out == mas_pkg::ERR_AXIS_CONFL)
         else $error("rising select left axis unlocked");
      AST_MAN_OK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_06]
         manual_own[i] && manual_cmd_in[i] && manual_ilk_n_in[i] |=> manual_axis_enable_out[i])
         else $error("manual command refused on owned axis");
      AST_HANDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_15]
         handle_intr_in[i] && !eff_sel[i] && manual_ilk_n_in[i] |=> manual_axis_enable_out[i])
         else $error("handle interrupt refused");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error and hold
   logic         conflict;
   logic         limit_hit;
   logic         coord_pend_ff;
   logic         coord_word_ff;
   logic         manual_busy;

   // [RULE_03] Auto command on manual axis
   assign conflict    = any_bit(auto_cmd_in & eff_sel) | any_bit(sel_rise & axis_moving_in);
   // [RULE_14] Limit trip on manual axis
   assign limit_hit   = combined & any_bit(limit_trip_in & manual_own);
   assign manual_busy = any_bit(eff_sel & axis_moving_in);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_error_out       <= mas_pkg::ERR_NONE;
         auto_interlock_out <= 1'b0;
      end else if (conflict) begin
         // [RULE_03] Set wins over clear
         op_error_out       <= mas_pkg::ERR_AXIS_CONFL;
         auto_interlock_out <= 1'b1;
      end else if (coord_pend_ff && !manual_busy && coord_word_ff) begin
         // [RULE_13] Axis word error
         op_error_out <= mas_pkg::ERR_COORD_WORD;
      end else if (error_clear_in) begin
         op_error_out       <= mas_pkg::ERR_NONE;
         auto_interlock_out <= 1'b0;
      end
   end

   // [RULE_13] Defer coordinate commands
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         coord_pend_ff  <= 1'b0;
         coord_word_ff  <= 1'b0;
         coord_exec_out <= 1'b0;
      end else begin
         coord_exec_out <= 1'b0;
         if (coord_pend_ff && !manual_busy) begin
            coord_pend_ff  <= 1'b0;
            coord_exec_out <= ~coord_word_ff;
         end else if (coord_cmd_in && !coord_pend_ff) begin
            coord_pend_ff <= 1'b1;
            coord_word_ff <= coord_axis_word_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         feed_hold_out <= 1'b0;
      else if (limit_hit)
         feed_hold_out <= 1'b1;
      else
         feed_hold_out <= feed_hold_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Axis enables
   logic [N-1:0] auto_gate;
   logic [N-1:0] man_gate;
   logic         auto_halt;

   // [RULE_12] Holds stop auto axes only
   assign auto_halt = single_block_stop_in | feed_hold_in | limit_hit | auto_interlock_out;
   // [RULE_10] [RULE_17] Interlock routing, low applies
   // [RULE_15] Handle interrupt on unselected axes
   assign auto_gate = auto_ilk_n_in & ~eff_sel & ~stopping & {N{~auto_halt}};
   // [RULE_07] Reject manual on unselected axes
   assign man_gate  = manual_ilk_n_in & ((manual_own & manual_cmd_in) | (~eff_sel & handle_intr_in));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auto_axis_enable_out   <= N'(mas_pkg::AXES_RST);
         manual_axis_enable_out <= N'(mas_pkg::AXES_RST);
         decel_stop_out         <= N'(mas_pkg::AXES_RST);
         combined_mode_out      <= 1'b0;
      end else begin
         auto_axis_enable_out   <= auto_gate;
         manual_axis_enable_out <= man_gate;
         decel_stop_out         <= stopping | (limit_hit ? ~manual_own : '0);
         combined_mode_out      <= combined;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feedrates, overrides, status
   // [RULE_08] [RULE_09] [RULE_11] Class-separated feed data
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auto_feed_out         <= 16'h0000;
         manual_feed_out       <= 16'h0000;
         auto_accel_mode_out   <= mas_pkg::MOVE_NONE;
         manual_accel_mode_out <= mas_pkg::MOVE_NONE;
         auto_cut_ovr_out      <= 8'h00;
         manual_cut_ovr_out    <= 8'h00;
         auto_rapid_ovr_out    <= 8'h00;
         manual_rapid_ovr_out  <= 8'h00;
         in_cutting_out        <= 1'b0;
         in_rapid_out          <= 1'b0;
      end else begin
         auto_feed_out         <= auto_feed_in;
         manual_feed_out       <= manual_feed_in;
         auto_accel_mode_out   <= auto_move_mode_in;
         manual_accel_mode_out <= manual_move_mode_in;
         auto_cut_ovr_out      <= ovr_cancel_in ? 8'h64 : (tap_modal_in ? cut_ovr_in : cut2_ovr_in);
         manual_cut_ovr_out    <= manual_cut_ovr_en_in ? cut_ovr_in : 8'h64;
         auto_rapid_ovr_out    <= ovr_cancel_in ? 8'h64 : rapid_ovr_in;
         manual_rapid_ovr_out  <= rapid_ovr_in;
         in_cutting_out        <= (auto_move_mode_in == mas_pkg::MOVE_CUT) & any_bit(auto_gate);
         in_rapid_out          <= (auto_move_mode_in == mas_pkg::MOVE_RAPID) & any_bit(auto_gate);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_COMBINED: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_01]
      combined_mode_out == $past(auto_sel_ff & man_sel_ff))
      else $error("combined mode wrong");
   AST_ERR5: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_03]
      conflict |=> op_error_out == mas_pkg::ERR_AXIS_CONFL && auto_interlock_out)
      else $error("error 0005 missing");
   AST_NO_SEL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_04]
      !combined && !auto_halt && stopping == '0 |=> auto_axis_enable_out == $past(auto_ilk_n_in))
      else $error("select bits applied outside combined");
   AST_MAN_REJ: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_07]
      (manual_axis_enable_out & ~$past(manual_own) & ~$past(handle_intr_in)) == '0)
      else $error("manual on unselected axis");
   AST_ILK: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_10]
      (auto_axis_enable_out & ~$past(auto_ilk_n_in)) == '0)
      else $error("auto interlock ignored");
   AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_14]
      limit_hit |=> feed_hold_out)
      else $error("limit did not hold");
   AST_CUT_OVR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_09]
      !manual_cut_ovr_en_in |=> manual_cut_ovr_out == 8'h64)
      else $error("manual cut override leaked");
   AST_AUTO_OVR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_09]
      ovr_cancel_in |=> auto_cut_ovr_out == 8'h64 && auto_rapid_ovr_out == 8'h64)
      else $error("override cancel ignored");
   AST_HALT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_12]
      auto_halt |=> auto_axis_enable_out == '0)
      else $error("auto axis ran through hold");
   AST_MAN_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_12]
      (feed_hold_in || single_block_stop_in)
         && (manual_own & manual_cmd_in & manual_ilk_n_in) != '0 |=> manual_axis_enable_out != '0)
      else $error("hold stopped manual axis");
   AST_FEED_SEP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_08]
      1'b1 |=> auto_feed_out == $past(auto_feed_in) && manual_feed_out == $past(manual_feed_in)
         && auto_accel_mode_out == $past(auto_move_mode_in)
         && manual_accel_mode_out == $past(manual_move_mode_in))
      else $error("feed data crossed classes");
   AST_CUT_STATUS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_11]
      in_cutting_out |-> auto_axis_enable_out != '0
         && $past(auto_move_mode_in) == mas_pkg::MOVE_CUT)
      else $error("cutting status not from auto axes");
   AST_RAPID_STATUS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_11]
      in_rapid_out |-> auto_axis_enable_out != '0
         && $past(auto_move_mode_in) == mas_pkg::MOVE_RAPID)
      else $error("rapid status not from auto axes");
   AST_COORD_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE_13]
      coord_pend_ff && manual_busy |=> !coord_exec_out)
      else $error("coordinate command ran during manual motion");

endmodule // manual_auto_simultaneous_axis_ctrl
`default_nettype wire

// ### tb/plc_seq_model.sv
/*
 PLC sequence model: mode selects and per-axis select bits, renewed once a scan.
 Assumes the bench sets the wanted levels; outputs change on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module plc_seq_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Wanted levels
   input  wire logic [2:0] want_auto_in,
   input  wire logic [3:0] want_manual_in,
   input  wire logic [7:0] want_select_in,
   // To the controller
   output logic            scan_strobe_out,
   output logic [2:0]      auto_mode_out,
   output logic [3:0]      manual_mode_out,
   output logic [7:0]      select_out
);
   logic [1:0] scan_cnt;
   // one bit per axis, once a scan
   always @(negedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_cnt <= 2'h0;
         scan_strobe_out <= 1'b0;
         {auto_mode_out, manual_mode_out, select_out} <= '0;
      end else begin
         scan_cnt <= scan_cnt + 2'h1;
         scan_strobe_out <= (scan_cnt == 2'h3);
         if (scan_cnt == 2'h3) begin
            {auto_mode_out, manual_mode_out} <= {want_auto_in, want_manual_in};
            select_out <= want_select_in;
         end
      end
   end
endmodule // plc_seq_model
`default_nettype wire

// ### tb/test_manual_auto_simultaneous_axis_ctrl.sv
/*
 Self-checking bench for the manual/automatic axis arbiter.
 Assumes the PLC model is compiled first; inputs change on falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module test_manual_auto_simultaneous_axis_ctrl;
   typedef struct {int id; logic [31:0] v;} note_t;
   logic        clk_in, rst_n_in, tap_modal_in, coord_cmd_in, coord_axis_word_in;
   logic        error_clear_in, single_block_stop_in, feed_hold_in, scan_strobe_in;
   logic        manual_cut_ovr_en_in, ovr_cancel_in, combined_mode_out, auto_interlock_out;
   logic        feed_hold_out, coord_exec_out, in_cutting_out, in_rapid_out;
   logic [2:0]  want_auto, auto_modes;
   logic [3:0]  want_man, man_modes;
   logic [7:0]  want_sel, manual_during_auto_axis_select_in, auto_cmd_in, manual_cmd_in;
   logic [7:0]  handle_intr_in, axis_moving_in, limit_trip_in, manual_ilk_n_in, auto_ilk_n_in;
   logic [7:0]  rapid_ovr_in, cut_ovr_in, cut2_ovr_in, auto_cut_ovr_out, manual_cut_ovr_out;
   logic [7:0]  auto_rapid_ovr_out, manual_rapid_ovr_out, auto_axis_enable_out;
   logic [7:0]  manual_axis_enable_out, decel_stop_out, exp_man, exp_auto;
   logic [15:0] auto_feed_in, manual_feed_in, op_error_out, auto_feed_out, manual_feed_out;
   logic [1:0]  auto_move_mode_in, manual_move_mode_in;
   logic [1:0]  auto_accel_mode_out, manual_accel_mode_out;
   note_t       q[$];
   note_t       n;
   logic [31:0] got;
   int          errors = 0, samples_checked = 0, cycles = 0, i, j;

   plc_seq_model u_plc_seq_model (
      .clk_in, .rst_n_in, .want_auto_in(want_auto), .want_manual_in(want_man),
      .want_select_in(want_sel), .scan_strobe_out(scan_strobe_in), .auto_mode_out(auto_modes),
      .manual_mode_out(man_modes), .select_out(manual_during_auto_axis_select_in));
   manual_auto_simultaneous_axis_ctrl u_manual_auto_simultaneous_axis_ctrl (
      .clk_in, .rst_n_in, .scan_strobe_in, .mode_tape_in(auto_modes[0]),
      .mode_mdi_in(auto_modes[1]), .mode_memory_in(auto_modes[2]), .mode_handle_in(man_modes[0]),
      .mode_step_in(man_modes[1]), .mode_jog_in(man_modes[2]), .mode_refret_in(man_modes[3]),
      .manual_during_auto_axis_select_in, .auto_cmd_in, .tap_modal_in, .manual_cmd_in,
      .handle_intr_in, .axis_moving_in, .limit_trip_in, .coord_cmd_in, .coord_axis_word_in,
      .error_clear_in, .manual_ilk_n_in, .auto_ilk_n_in, .single_block_stop_in, .feed_hold_in,
      .rapid_ovr_in, .cut_ovr_in, .cut2_ovr_in, .manual_cut_ovr_en_in, .ovr_cancel_in,
      .auto_feed_in, .manual_feed_in, .auto_move_mode_in, .manual_move_mode_in,
      .combined_mode_out, .op_error_out, .auto_interlock_out, .feed_hold_out,
      .auto_axis_enable_out, .manual_axis_enable_out, .decel_stop_out, .coord_exec_out,
      .in_cutting_out, .in_rapid_out, .auto_feed_out, .manual_feed_out, .auto_accel_mode_out,
      .manual_accel_mode_out, .auto_cut_ovr_out, .manual_cut_ovr_out, .auto_rapid_ovr_out,
      .manual_rapid_ovr_out);

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic wrap_up;
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Note an expectation; the monitor takes it at the next falling edge
   task automatic chk(input int id, input logic [31:0] v);
      @(posedge clk_in);
      #1 q.push_back('{id, v});
      @(negedge clk_in);
   endtask

   // Covers one scan, the mode latency and the answer cycle
   task automatic settle;
      repeat (10) @(negedge clk_in);
   endtask

   always @(negedge clk_in) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         case (n.id)
            0: got = 32'(combined_mode_out);
            1: got = {op_error_out, 15'h0000, auto_interlock_out};
            2: got = 32'(feed_hold_out);
            3: got = {16'h0000, manual_axis_enable_out, auto_axis_enable_out};
            4: got = {26'h0, auto_accel_mode_out, manual_accel_mode_out,
                      in_cutting_out, in_rapid_out};
            5: got = {auto_feed_out, manual_feed_out};
            6: got = 32'(decel_stop_out);
            7: got = {auto_cut_ovr_out, auto_rapid_ovr_out,
                      manual_rapid_ovr_out, manual_cut_ovr_out};
            default: got = 32'(coord_exec_out);
         endcase
         samples_checked++;
         if (got !== n.v) begin
            errors++;
            $display("MISMATCH %0t note %0d exp %h got %h", $time, n.id, n.v, got);
         end
      end
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      i = $urandom(32'h4163);
      {tap_modal_in, coord_cmd_in, coord_axis_word_in, error_clear_in} = '0;
      {single_block_stop_in, feed_hold_in, manual_cut_ovr_en_in, ovr_cancel_in} = '0;
      {want_auto, want_man, want_sel, auto_cmd_in, manual_cmd_in, handle_intr_in} = '0;
      {axis_moving_in, limit_trip_in, rapid_ovr_in, cut_ovr_in, cut2_ovr_in} = '0;
      {auto_feed_in, manual_feed_in, auto_move_mode_in, manual_move_mode_in} = '0;
      manual_ilk_n_in = 8'hFF;
      auto_ilk_n_in = 8'hFF;
      rst_n_in = 1'b0;
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      chk(0, 32'h0);
      chk(1, 32'h0);
      want_auto = 3'h1;
      want_sel = 8'h01;
      auto_cmd_in = 8'h01;
      settle();
      chk(0, 32'h0);
      chk(1, 32'h0);
      chk(3, 32'h0000_00FF);
      auto_cmd_in = 8'h00;
      for (i = 0; i < 3; i++) begin
         for (j = 0; j < 4; j++) begin
            want_auto = 3'(1 << i);
            want_man = 4'(1 << j);
            settle();
            chk(0, 32'h1);
         end
      end
      want_auto = 3'h0;
      settle();
      chk(0, 32'h0);
      want_auto = 3'h1;
      want_man = 4'h4;
      settle();
      auto_cmd_in = 8'h01;
      settle();
      chk(1, {mas_pkg::ERR_AXIS_CONFL, 16'h0001});
      auto_cmd_in = 8'h00;
      error_clear_in = 1'b1;
      @(negedge clk_in);
      error_clear_in = 1'b0;
      settle();
      chk(1, 32'h0);
      for (i = 0; i < 8; i++) begin
         want_sel = 8'($urandom);
         manual_ilk_n_in = 8'($urandom);
         manual_cmd_in = 8'($urandom);
         {feed_hold_in, single_block_stop_in} = 2'($urandom);
         settle();
         exp_man = manual_cmd_in & want_sel & manual_ilk_n_in;
         exp_auto = (feed_hold_in | single_block_stop_in) ? 8'h00 : ~want_sel;
         chk(3, {16'h0, exp_man, exp_auto});
      end
      {manual_cmd_in, feed_hold_in, single_block_stop_in} = {8'h00, 2'b00};
      manual_ilk_n_in = 8'h00;
      want_sel = 8'h01;
      settle();
      auto_cmd_in = 8'h02;
      auto_ilk_n_in = 8'hFD;
      settle();
      chk(3, 32'h0000_00FC);
      auto_ilk_n_in = 8'hFF;
      axis_moving_in = 8'h02;
      auto_move_mode_in = mas_pkg::MOVE_CUT;
      manual_move_mode_in = mas_pkg::MOVE_RAPID;
      {auto_feed_in, manual_feed_in} = $urandom;
      {rapid_ovr_in, cut_ovr_in, cut2_ovr_in} = 24'($urandom);
      ovr_cancel_in = 1'b1;
      settle();
      chk(3, 32'h0000_00FE);
      chk(4, {26'h0, mas_pkg::MOVE_CUT, mas_pkg::MOVE_RAPID, 2'b10});
      chk(5, {auto_feed_in, manual_feed_in});
      chk(7, {8'h64, 8'h64, rapid_ovr_in, 8'h64});
      {manual_cut_ovr_en_in, ovr_cancel_in} = 2'b10;
      chk(7, {cut2_ovr_in, rapid_ovr_in, rapid_ovr_in, cut_ovr_in});
      auto_move_mode_in = mas_pkg::MOVE_RAPID;
      manual_move_mode_in = mas_pkg::MOVE_CUT;
      settle();
      chk(4, {26'h0, mas_pkg::MOVE_RAPID, mas_pkg::MOVE_CUT, 2'b01});
      limit_trip_in = 8'h01;
      settle();
      chk(2, 32'h1);
      chk(6, 32'hFE);
      chk(3, 32'h0);
      {limit_trip_in, manual_ilk_n_in, rst_n_in} = {8'h00, 8'hFF, 1'b0};
      @(negedge clk_in);
      rst_n_in = 1'b1;
      {auto_cmd_in, axis_moving_in} = {8'h04, 8'h04};
      settle();
      want_sel = 8'h05;
      settle();
      chk(6, 32'h4);
      chk(1, {mas_pkg::ERR_AXIS_CONFL, 16'h0001});
      {auto_cmd_in, axis_moving_in, manual_cmd_in} = {8'h00, 8'h00, 8'h04};
      settle();
      chk(6, 32'h0);
      chk(3, {16'h0, 8'h04, 8'h00});
      {axis_moving_in, coord_cmd_in} = {8'h04, 1'b1};
      @(negedge clk_in);
      coord_cmd_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk(8, 32'h0);
      axis_moving_in = 8'h00;
      chk(8, 32'h1);
      error_clear_in = 1'b1;
      @(negedge clk_in);
      {error_clear_in, coord_cmd_in, coord_axis_word_in, axis_moving_in} = {2'b01, 1'b1, 8'h04};
      @(negedge clk_in);
      coord_cmd_in = 1'b0;
      repeat (3) @(negedge clk_in);
      axis_moving_in = 8'h00;
      chk(8, 32'h0);
      chk(1, {mas_pkg::ERR_COORD_WORD, 16'h0000});
      {handle_intr_in, manual_cmd_in} = {8'hFF, 8'h00};
      chk(3, {16'h0, 8'hFA, 8'hFA});
      wrap_up();
   end
endmodule // test_manual_auto_simultaneous_axis_ctrl
`default_nettype wire
